// ==== hw/spsq_pkg.sv ====
// shared constants, register map and types of the slot power sequencer
package spsq_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int             RAIL_NUM  = 10;           // regulator enables
	localparam int             OUT_NUM   = 12;           // rails plus power good plus host reset
	localparam int             PG_IDX    = 10;
	localparam int             RST_IDX   = 11;
	localparam int             SLOT_W    = 8;
	localparam logic [7:0]     SLOT_LAST = 8'hfe;        // last usable slot, 254
	localparam logic [7:0]     SLOT_OFF  = 8'hff;        // output never switched
	localparam int             ADDR_W    = 8;
	localparam int             DATA_W    = 32;
	localparam int             TB_CYC_W  = 16;

	// ----------------------------------------------------------------
	// time base
	// ----------------------------------------------------------------
	localparam int             CLK_PERIOD_NS = 20;
	localparam int             TB30_NS   = 30000;
	localparam int             TB120_NS  = 120000;
	localparam int             TB250_NS  = 250000;
	localparam int             TB500_NS  = 500000;
	localparam int             TB30_CYC  = (TB30_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int             TB120_CYC = (TB120_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int             TB250_CYC = (TB250_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int             TB500_CYC = (TB500_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0]     TB_SEL_30  = 2'h0;
	localparam logic [1:0]     TB_SEL_120 = 2'h1;
	localparam logic [1:0]     TB_SEL_250 = 2'h2;
	localparam logic [1:0]     TB_SEL_500 = 2'h3;

	// ----------------------------------------------------------------
	// one-time-programmable defaults, index 0 in the low byte
	// ----------------------------------------------------------------
	localparam logic [OUT_NUM*SLOT_W-1:0] OTP_SLOTS = {
		8'h0f, 8'h0f,                                  // host reset, power good
		8'h0e, 8'h0d, 8'h07, 8'h02, 8'h08,             // rails 9..5
		8'h03, 8'h01, 8'h06, 8'h04, 8'h05};            // rails 4..0
	localparam logic [1:0]     OTP_TB_SEL = TB_SEL_500;

	// ----------------------------------------------------------------
	// register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0]     REG_SLOT_BASE = 8'h00;   // one word per output
	localparam logic [7:0]     REG_TB        = 8'h30;
	localparam logic [7:0]     REG_STAT      = 8'h34;
	localparam int             STAT_CNT_LSB   = 0;
	localparam int             STAT_FAULT_BIT = 8;
	localparam int             STAT_STATE_LSB = 9;
	localparam int             STAT_LINE_BIT  = 11;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_OFF  = 2'b00,
		ST_UP   = 2'b01,
		ST_ON   = 2'b10,
		ST_DOWN = 2'b11
	} spsq_state_type;

	typedef enum logic [1:0] {
		MODE_CLEAR = 2'b00,
		MODE_RISE  = 2'b01,
		MODE_FALL  = 2'b10
	} spsq_mode_type;

endpackage : spsq_pkg

// ==== hw/spsq_tick.sv ====
// time base divider producing one pulse per slot period
`timescale 1ns/100ps
module spsq_tick (
	input  wire logic                          CLK,
	input  wire logic                          NRST,
	input  wire logic                          RUN,
	input  wire logic                          EN,
	input  wire logic [spsq_pkg::TB_CYC_W-1:0] LIMIT,
	output logic                               TICK
);
	import spsq_pkg::*;

	logic [TB_CYC_W-1:0] cnt;
	logic [TB_CYC_W-1:0] next_cnt;
	logic                next_tick;

	// count only while running and enabled; >= guards a limit shrunk mid period
	always_comb begin
		next_cnt  = cnt;
		next_tick = 1'b0;
		if (!RUN) begin
			next_cnt = '0;
		end else if (EN) begin
			if (cnt >= LIMIT - 16'h0001) begin
				next_cnt  = '0;
				next_tick = 1'b1;
			end else begin
				next_cnt = cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			cnt  <= '0;
			TICK <= 1'b0;
		end else begin
			cnt  <= next_cnt;
			TICK <= next_tick;
		end
	end

	// a pulse only appears while the divider is allowed to run
	tick_gated_a: assert property (@(posedge CLK) disable iff (!NRST)
		TICK |-> $past(RUN) && $past(EN)) else $error("tick without run and enable");

endmodule : spsq_tick

// ==== hw/spsq_cell.sv ====
// one switched output that turns on at its slot and off at its mirrored slot
`timescale 1ns/100ps
module spsq_cell (
	input  wire logic                     CLK,
	input  wire logic                     NRST,
	input  wire logic [1:0]               MODE,
	input  wire logic [spsq_pkg::SLOT_W-1:0] COUNT,
	input  wire logic [spsq_pkg::SLOT_W-1:0] SLOT,
	input  wire logic                     ALLOW,
	output logic                          ON
);
	import spsq_pkg::*;

	logic next_on;

	// rising uses the slot as is, falling uses it mirrored from the last slot
	always_comb begin
		next_on = 1'b0;
		unique case (MODE)
			MODE_RISE: begin
				next_on = ALLOW && (ON || (SLOT != SLOT_OFF && COUNT >= SLOT));
			end
			MODE_FALL: begin
				next_on = ON && SLOT != SLOT_OFF && COUNT < SLOT_LAST - SLOT;
			end
			default: begin
				next_on = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ON <= 1'b0;
		end else begin
			ON <= next_on;
		end
	end

	// an output never switches on early
	cell_rise_a: assert property (@(posedge CLK) disable iff (!NRST)
		$rose(ON) |-> $past(COUNT) >= $past(SLOT) && $past(MODE) == MODE_RISE)
		else $error("output turned on before its slot");

endmodule : spsq_cell

// ==== hw/spsq_top.sv ====
// slot power sequencer: configuration registers, sequence state and sync line
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps

module spsq_top #(
	parameter int TB0_CYC = spsq_pkg::TB30_CYC,
	parameter int TB1_CYC = spsq_pkg::TB120_CYC,
	parameter int TB2_CYC = spsq_pkg::TB250_CYC,
	parameter int TB3_CYC = spsq_pkg::TB500_CYC
) (
	input  wire logic                            CLK,
	input  wire logic                            NRST,
	input  wire logic [spsq_pkg::ADDR_W-1:0]     ADDR,
	input  wire logic [spsq_pkg::DATA_W-1:0]     WDATA,
	input  wire logic                            WR,
	input  wire logic                            RD,
	output logic      [spsq_pkg::DATA_W-1:0]     RDATA,
	input  wire logic                            POWER_ON_REQUEST,
	input  wire logic                            SUPPLY_READY,
	input  wire logic [spsq_pkg::RAIL_NUM-1:0]   RAIL_FAULT,
	output logic      [spsq_pkg::RAIL_NUM-1:0]   RAIL_ENABLE,
	output logic                                 POWER_GOOD_OUT,
	output logic                                 HOST_RESET_OUT_N,
	input  wire logic                            SEQUENCE_SYNC_LINE_I,
	output logic                                 SEQUENCE_SYNC_LINE_O,
	output logic                                 SEQUENCE_SYNC_LINE_OE_N
);
	import spsq_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [SLOT_W-1:0]   slot_cfg [OUT_NUM];
	logic [SLOT_W-1:0]   next_slot_cfg [OUT_NUM];
	logic [1:0]          tb_sel;
	logic [1:0]          next_tb_sel;
	logic [DATA_W-1:0]   next_rdata;
	spsq_state_type      state;
	spsq_state_type      next_state;
	logic [SLOT_W-1:0]   count;
	logic [SLOT_W-1:0]   next_count;
	logic                fault_seen;
	logic                next_fault_seen;
	logic                next_oe_n;
	logic [TB_CYC_W-1:0] tb_limit;
	logic                busy;
	logic                tick;
	logic                fault_now;
	logic [1:0]          cell_mode;
	logic [OUT_NUM-1:0]  out_on;
	logic [OUT_NUM-1:0]  allow;
	logic [5:0]          word_idx;

	assign word_idx = ADDR[7:2];

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	// writes are taken in any state; a slot changed mid sequence acts at once
	always_comb begin
		for (int i = 0; i < OUT_NUM; i++) begin
			next_slot_cfg[i] = slot_cfg[i];
			if (WR && ADDR[1:0] == 2'h0 && int'(word_idx) == i) begin
				next_slot_cfg[i] = WDATA[SLOT_W-1:0];
			end
		end
		next_tb_sel = tb_sel;
		if (WR && ADDR == REG_TB) begin
			next_tb_sel = WDATA[1:0];
		end
	end

	// read data stand only in the cycle after the strobe, unmapped reads give zero
	always_comb begin
		next_rdata = '0;
		if (RD) begin
			if (ADDR[1:0] == 2'h0 && int'(word_idx) < OUT_NUM) begin
				next_rdata[SLOT_W-1:0] = slot_cfg[word_idx[3:0]];
			end else if (ADDR == REG_TB) begin
				next_rdata[1:0] = tb_sel;
			end else if (ADDR == REG_STAT) begin
				next_rdata[STAT_CNT_LSB +: SLOT_W]  = count;
				next_rdata[STAT_FAULT_BIT]         = fault_seen;
				next_rdata[STAT_STATE_LSB +: 2]    = state;
				next_rdata[STAT_LINE_BIT]          = SEQUENCE_SYNC_LINE_I;
			end
		end
	end

	// reset loads the programmed defaults, so the default sequence needs no software
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			for (int i = 0; i < OUT_NUM; i++) begin
				slot_cfg[i] <= OTP_SLOTS[i*SLOT_W +: SLOT_W];
			end
			tb_sel <= OTP_TB_SEL;
			RDATA  <= '0;
		end else begin
			for (int i = 0; i < OUT_NUM; i++) begin
				slot_cfg[i] <= next_slot_cfg[i];
			end
			tb_sel <= next_tb_sel;
			RDATA  <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// time base
	// ----------------------------------------------------------------
	// the chosen base sets slot spacing for power-up and power-down alike
	always_comb begin
		tb_limit = TB_CYC_W'(TB0_CYC);
		unique case (tb_sel)
			TB_SEL_30:  tb_limit = TB_CYC_W'(TB0_CYC);
			TB_SEL_120: tb_limit = TB_CYC_W'(TB1_CYC);
			TB_SEL_250: tb_limit = TB_CYC_W'(TB2_CYC);
			TB_SEL_500: tb_limit = TB_CYC_W'(TB3_CYC);
		endcase
	end

	assign busy = (state == ST_UP) || (state == ST_DOWN);

	// the divider freezes while any sequencer holds the line low
	spsq_tick u_tick (
		.CLK   (CLK),
		.NRST  (NRST),
		.RUN   (busy),
		.EN    (SEQUENCE_SYNC_LINE_I),
		.LIMIT (tb_limit),
		.TICK  (tick)
	);

	// ----------------------------------------------------------------
	// sequence state
	// ----------------------------------------------------------------
	assign fault_now = |(RAIL_FAULT & RAIL_ENABLE);

	// a drop of the request during power-up mirrors the count so the rails
	// already on go down in reverse order without waiting for the last slot
	always_comb begin
		next_state      = state;
		next_count      = count;
		next_fault_seen = fault_seen;
		unique case (state)
			ST_OFF: begin
				if (POWER_ON_REQUEST && SUPPLY_READY) begin
					next_state      = ST_UP;
					next_count      = '0;
					next_fault_seen = 1'b0;
				end
			end
			ST_UP: begin
				next_fault_seen = fault_seen | fault_now;
				if (!POWER_ON_REQUEST) begin
					next_state = ST_DOWN;
					next_count = SLOT_LAST - count;
				end else if (tick && SEQUENCE_SYNC_LINE_I) begin
					if (count == SLOT_LAST) begin
						next_state = ST_ON;
					end else begin
						next_count = count + 8'h01;
					end
				end
			end
			ST_ON: begin
				next_fault_seen = fault_seen | fault_now;
				if (!POWER_ON_REQUEST) begin
					next_state = ST_DOWN;
					next_count = '0;
				end
			end
			ST_DOWN: begin
				if (tick && SEQUENCE_SYNC_LINE_I) begin
					if (count == SLOT_LAST) begin
						next_state = ST_OFF;
					end else begin
						next_count = count + 8'h01;
					end
				end
			end
		endcase
	end

	// pull the shared line low on a rail fault during power-up or on, or while a request waits for supply
	always_comb begin
		next_oe_n = 1'b1;
		if ((state != ST_OFF && state != ST_DOWN) && fault_now) begin
			next_oe_n = 1'b0;
		end else if (state == ST_OFF && POWER_ON_REQUEST && !SUPPLY_READY) begin
			next_oe_n = 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state                   <= ST_OFF;
			count                   <= '0;
			fault_seen              <= 1'b0;
			SEQUENCE_SYNC_LINE_OE_N <= 1'b1;
			SEQUENCE_SYNC_LINE_O    <= 1'b0;
		end else begin
			state                   <= next_state;
			count                   <= next_count;
			fault_seen              <= next_fault_seen;
			SEQUENCE_SYNC_LINE_OE_N <= next_oe_n;
			SEQUENCE_SYNC_LINE_O    <= 1'b0;      // open drain only ever pulls low
		end
	end

	// ----------------------------------------------------------------
	// switched outputs
	// ----------------------------------------------------------------
	always_comb begin
		cell_mode = MODE_CLEAR;
		unique case (state)
			ST_OFF:  cell_mode = MODE_CLEAR;
			ST_UP:   cell_mode = MODE_RISE;
			ST_ON:   cell_mode = MODE_RISE;
			ST_DOWN: cell_mode = MODE_FALL;
		endcase
	end

	// power good and reset release are vetoed by any fault seen so far
	always_comb begin
		allow          = '1;
		allow[PG_IDX]  = !fault_seen && !fault_now;
		allow[RST_IDX] = !fault_seen && !fault_now;
	end

	for (genvar g = 0; g < OUT_NUM; g++) begin : g_cell
		spsq_cell u_cell (
			.CLK   (CLK),
			.NRST  (NRST),
			.MODE  (cell_mode),
			.COUNT (count),
			.SLOT  (slot_cfg[g]),
			.ALLOW (allow[g]),
			.ON    (out_on[g])
		);
	end

	assign RAIL_ENABLE      = out_on[RAIL_NUM-1:0];
	assign POWER_GOOD_OUT   = out_on[PG_IDX];
	assign HOST_RESET_OUT_N = out_on[RST_IDX]; // high means released

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [TB_CYC_W-1:0] gap;

	// mirrors the divider count, so the first period after a start is judged like the rest
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			gap <= '0;
		end else if (!busy) begin
			gap <= '0;
		end else if (tick) begin
			gap <= {15'h0000, SEQUENCE_SYNC_LINE_I};
		end else if (SEQUENCE_SYNC_LINE_I) begin
			gap <= gap + 16'h0001;
		end
	end

	start_up_a: assert property (@(posedge CLK) disable iff (!NRST)
		state == ST_OFF && POWER_ON_REQUEST && SUPPLY_READY |=> state == ST_UP && count == 8'h00)
		else $error("power-up did not start on request");

	down_on_drop_a: assert property (@(posedge CLK) disable iff (!NRST)
		(state == ST_UP || state == ST_ON) && !POWER_ON_REQUEST |=> state == ST_DOWN)
		else $error("power-down did not start on request low");

	reset_fault_a: assert property (@(posedge CLK) disable iff (!NRST)
		fault_seen |=> !HOST_RESET_OUT_N && !POWER_GOOD_OUT)
		else $error("reset released after a fault");

	reset_slot_a: assert property (@(posedge CLK) disable iff (!NRST)
		$rose(HOST_RESET_OUT_N) |-> $past(count) >= $past(slot_cfg[RST_IDX])
			&& $past(state) != ST_DOWN && !$past(fault_seen))
		else $error("reset released before its slot");

	pause_sync_a: assert property (@(posedge CLK) disable iff (!NRST)
		(state == ST_DOWN || (state == ST_UP && POWER_ON_REQUEST)) && !SEQUENCE_SYNC_LINE_I
			|=> count == $past(count))
		else $error("slot advanced while sync line low");

	slot_spacing_a: assert property (@(posedge CLK) disable iff (!NRST)
		tick && busy |-> gap == tb_limit)
		else $error("slot period differs from time base");

	sync_pull_a: assert property (@(posedge CLK) disable iff (!NRST)
		state == ST_UP && fault_now |=> !SEQUENCE_SYNC_LINE_OE_N && !SEQUENCE_SYNC_LINE_O)
		else $error("sync line not pulled on fault");

	for (genvar r = 0; r < RAIL_NUM; r++) begin : g_chk
		rail_down_a: assert property (@(posedge CLK) disable iff (!NRST)
			$fell(RAIL_ENABLE[r]) |-> $past(state) != ST_UP
				&& ($past(state) == ST_OFF || $past(count) >= SLOT_LAST - $past(slot_cfg[r])))
			else $error("rail dropped outside its mirrored slot");
		rail_up_a: assert property (@(posedge CLK) disable iff (!NRST)
			$rose(RAIL_ENABLE[r]) |-> $past(count) >= $past(slot_cfg[r])
				&& ($past(state) == ST_UP || $past(state) == ST_ON))
			else $error("rail enabled out of slot order");
	end

endmodule : spsq_top

// ==== test/spsq_ctrl_model.sv ====
// far-side model: system controller plus a neighbour sequencer on the shared sync line
`timescale 1ns/100ps
module spsq_ctrl_model (
	input  wire logic                          clk,
	input  wire logic                          req_cmd,
	input  wire logic                          supply_cmd,
	input  wire logic [spsq_pkg::RAIL_NUM-1:0] fault_cmd,
	input  wire logic                          hold_cmd,
	input  wire logic                          host_reset_n,
	input  wire logic                          sync_o,
	input  wire logic                          sync_oe_n,
	output logic                               power_on_request,
	output logic                               supply_ready,
	output logic      [spsq_pkg::RAIL_NUM-1:0] rail_fault,
	output logic                               sync_i,
	output logic                               host_running
);
	import spsq_pkg::*;

	logic neighbour_pull;

	// ------------------------------------------------------------
	// controller levels
	// ------------------------------------------------------------
	// levels change just after the edge, never on it; unknown only while in reset
	always @(posedge clk) begin
		power_on_request <= req_cmd;
		supply_ready <= supply_cmd;
		rail_fault <= fault_cmd;
		neighbour_pull <= hold_cmd;
	end

	// ------------------------------------------------------------
	// shared line and host
	// ------------------------------------------------------------
	// wired-AND with pull-up: either party pulling low wins
	assign sync_i = (sync_oe_n | sync_o) & ~neighbour_pull;
	// the host only runs while its reset is released
	assign host_running = host_reset_n;
endmodule : spsq_ctrl_model

// ==== test/test_slot_power_sequencer.sv ====
// self-checking bench of the slot power sequencer
`timescale 1ns/100ps
module test_slot_power_sequencer;
	import spsq_pkg::*;

	// ------------------------------------------------------------
	// setup
	// ------------------------------------------------------------
	localparam int P [4] = '{4, 6, 8, 10};  // shortened slot periods
	localparam logic [7:0] SLOT_CFG [OUT_NUM] = '{8'h00, 8'h03, 8'h01, 8'h09, 8'h02,
		8'hc8, 8'h05, 8'h07, 8'h04, 8'h06, 8'h0c, 8'hfe};
	localparam int HOLD = 40;

	logic                clk, nrst, wr, rd, req_cmd, supply_cmd, hold_cmd;
	logic [7:0]          addr;
	logic [31:0]         wdata, rdata, d;
	logic [RAIL_NUM-1:0] fault_cmd, rail_fault, rail_enable;
	logic                power_on_request, supply_ready, power_good_out, host_reset_out_n;
	logic                sync_i, sync_o, sync_oe_n, req_q;
	logic [OUT_NUM-1:0]  outs, outs_q;
	int                  bad_count, samples_checked, cyc, t0;
	int                  edge_t [OUT_NUM];

	assign outs = {host_reset_out_n, power_good_out, rail_enable};

	spsq_top #(.TB0_CYC(P[0]), .TB1_CYC(P[1]), .TB2_CYC(P[2]), .TB3_CYC(P[3])) i_dut (
		.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.POWER_ON_REQUEST(power_on_request), .SUPPLY_READY(supply_ready),
		.RAIL_FAULT(rail_fault), .RAIL_ENABLE(rail_enable), .POWER_GOOD_OUT(power_good_out),
		.HOST_RESET_OUT_N(host_reset_out_n), .SEQUENCE_SYNC_LINE_I(sync_i),
		.SEQUENCE_SYNC_LINE_O(sync_o), .SEQUENCE_SYNC_LINE_OE_N(sync_oe_n));

	spsq_ctrl_model i_ctrl (
		.clk(clk), .req_cmd(req_cmd), .supply_cmd(supply_cmd), .fault_cmd(fault_cmd),
		.hold_cmd(hold_cmd), .host_reset_n(host_reset_out_n), .sync_o(sync_o),
		.sync_oe_n(sync_oe_n), .power_on_request(power_on_request),
		.supply_ready(supply_ready), .rail_fault(rail_fault), .sync_i(sync_i),
		.host_running());

	always #10 clk = ~clk;

	// edge stamps: request edge and every output change, pre-update values
	always @(posedge clk) begin
		cyc++;
		if (power_on_request !== req_q)
			t0 = cyc;
		for (int i = 0; i < OUT_NUM; i++)
			if (outs[i] !== outs_q[i])
				edge_t[i] = cyc;
		req_q = power_on_request;
		outs_q = outs;
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	// timing is judged in a small window: a slot off by one misses it
	task automatic check_win(input int got, input int lo, input int hi, input string what);
		samples_checked++;
		if (got < lo || got > hi) begin
			bad_count++;
			$display("ERROR %0t %s: offset %0d outside %0d..%0d", $time, what, got, lo, hi);
		end
	endtask : check_win

	task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_write

	// data stand only in the cycle after the strobe, so take them mid-cycle
	task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask : reg_read

	task automatic wait_mask(input logic [OUT_NUM-1:0] m, input logic [OUT_NUM-1:0] w,
		input int limit);
		int n;
		n = 0;
		while ((outs & m) !== w && n < limit) begin
			@(posedge clk);
			n++;
		end
		// half a cycle on, so the edge stamps of this edge are surely taken
		@(negedge clk);
		check(32'(outs & m), 32'(w), "outputs settle");
	endtask : wait_mask

	task automatic power_cycle(input int sel);
		for (int i = 0; i < OUT_NUM; i++)
			reg_write(REG_SLOT_BASE + 8'(4 * i), {24'h0, SLOT_CFG[i]});
		reg_write(REG_TB, 32'(sel));
		req_cmd <= 1'b1;
		wait_mask('1, '1, 256 * P[sel] + 20);
		for (int i = 0; i < OUT_NUM; i++)
			check_win(edge_t[i] - t0 - SLOT_CFG[i] * P[sel], 1, 4, "up slot");
		// let the last slot run out so power-down starts from a fresh period
		repeat (2 * P[sel]) @(posedge clk);
		req_cmd <= 1'b0;
		wait_mask('1, '0, 256 * P[sel] + 20);
		for (int i = 0; i < OUT_NUM; i++)
			check_win(edge_t[i] - t0 - (254 - SLOT_CFG[i]) * P[sel], 1, 4, "down slot");
		// reach the off state before the next time base write lands
		repeat (2 * P[3]) @(posedge clk);
		$display("test power cycle with time base %0d done", sel);
	endtask : power_cycle

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude

	// ------------------------------------------------------------
	// watchdog
	// ------------------------------------------------------------
	// the whole sequence needs roughly 17000 cycles
	initial begin
		repeat (80000) @(posedge clk);
		bad_count++;
		$display("ERROR %0t watchdog expired", $time);
		conclude();
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = '0;
		wdata = '0;
		req_cmd = 1'b0;
		supply_cmd = 1'b1;
		hold_cmd = 1'b0;
		fault_cmd = '0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		// defaults straight after reset, no software involved
		check({sync_oe_n, 19'h0, outs}, 32'h8000_0000, "outputs after reset");
		for (int i = 0; i < OUT_NUM; i++) begin
			reg_read(REG_SLOT_BASE + 8'(4 * i), d);
			check(d, {24'h0, OTP_SLOTS[i * 8 +: 8]}, "default slot");
		end
		reg_read(REG_TB, d);
		check(d, 32'(OTP_TB_SEL), "default time base");
		reg_write(REG_STAT, 32'hffff_ffff);
		reg_read(REG_STAT, d);
		check(d, 32'h1 << STAT_LINE_BIT, "status read only");
		reg_read(8'h40, d);
		check(d, 32'h0, "unmapped read");
		reg_write(REG_SLOT_BASE, 32'hffff_ff2a);
		reg_read(REG_SLOT_BASE, d);
		check(d, 32'h2a, "slot field width");
		$display("test register defaults done");

		for (int s = 0; s < 4; s++)
			power_cycle(s);

		// a rail fault keeps the host in reset and pulls the sync line
		reg_write(REG_TB, 32'(TB_SEL_30));
		req_cmd <= 1'b1;
		wait_mask(12'h001, 12'h001, 20);
		fault_cmd <= 10'h001;
		repeat (3) @(posedge clk);
		@(negedge clk);
		check(32'({sync_o, sync_oe_n}), 32'h0, "fault pulls line");
		@(posedge clk);
		fault_cmd <= '0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		check(32'(sync_oe_n), 32'h1, "line freed");
		repeat (260 * P[0]) @(posedge clk);
		check(32'(outs[RST_IDX:PG_IDX]), 32'h0, "host held in reset");
		reg_read(REG_STAT, d);
		check(d[STAT_FAULT_BIT+:3], {ST_ON, 1'b1}, "fault seen, sequence on");
		req_cmd <= 1'b0;
		wait_mask('1, '0, 260 * P[0]);
		repeat (2 * P[3]) @(posedge clk);
		$display("test rail fault done");

		// neighbour holds the line low: the slot count must stand still
		reg_write(REG_TB, 32'(TB_SEL_500));
		req_cmd <= 1'b1;
		wait_mask(12'h001, 12'h001, 20);
		hold_cmd <= 1'b1;
		reg_read(REG_STAT, d);
		check(32'(d[STAT_LINE_BIT]), 32'h0, "line seen low");
		repeat (HOLD - 3) @(posedge clk);
		hold_cmd <= 1'b0;
		wait_mask(12'h004, 12'h004, HOLD + 4 * P[3]);
		check_win(edge_t[2] - t0 - P[3] - HOLD, 1, 5, "slot held by line");
		req_cmd <= 1'b0;
		wait_mask('1, '0, 260 * P[3]);
		repeat (2 * P[3]) @(posedge clk);
		$display("test sync hold done");

		// no supply: request waits and the line is pulled
		reg_write(REG_TB, 32'(TB_SEL_30));
		supply_cmd <= 1'b0;
		req_cmd <= 1'b1;
		repeat (6) @(posedge clk);
		@(negedge clk);
		check({sync_oe_n, 19'h0, outs}, 32'h0, "waiting for supply");
		@(posedge clk);
		supply_cmd <= 1'b1;
		wait_mask(12'h001, 12'h001, 20);
		req_cmd <= 1'b0;
		wait_mask('1, '0, 260 * P[0]);
		$display("test supply wait done");
		conclude();
	end
endmodule : test_slot_power_sequencer
